//--- inc/updown_timer_map.vh
`ifndef UPDOWN_TIMER_MAP_VH
`define UPDOWN_TIMER_MAP_VH

// special function register addresses
`define ADDR_TIMER_CONTROL   8'hc8
`define ADDR_TIMER_CONFIG    8'hc9
`define ADDR_RELOAD_LOW      8'hca
`define ADDR_RELOAD_HIGH     8'hcb
`define ADDR_COUNT_LOW       8'hcc
`define ADDR_COUNT_HIGH      8'hcd

// control register fields
`define CTL_CAPTURE_RELOAD   0
`define CTL_COUNTER_SELECT   1
`define CTL_RUN              2
`define CTL_MASK             8'h07

// configuration register fields
`define CFG_DECREMENT_ENABLE 0
`define CFG_TOGGLE_OE        1
`define CFG_TOGGLE_STATE     2
`define CFG_CLOCK_MODE_LO    3
`define CFG_CLOCK_MODE_HI    4
`define CFG_MASK             8'h1b

// reset values
`define RESET_CONTROL        8'h00
`define RESET_CONFIG         8'h00
`define RESET_BYTE           8'h00

// clock mode codes
`define MODE_DIV12           2'b00
`define MODE_DIV1            2'b01
`define MODE_EXT_DIV8        2'b10
`define MODE_DIV2            2'b11

// prescale counts
`define DIV12_LAST           4'hb
`define EXT_DIV8_LAST        3'h7
`define COUNT_FULL           16'hffff

`endif

//--- rtl/pin_sync.v
`timescale 1ns/1ps

// two-stage synchroniser for asynchronous pin levels
module pin_sync #(
	parameter WIDTH = 3
) (
	input  wire             clock,
	input  wire             srst,
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_sync_out
);

	reg [WIDTH-1:0] stage1_r;  // first stage, read only by second stage

	// two flip-flops per bit, reset to low
	always @(posedge clock) begin
		if (srst) begin
			stage1_r     <= {WIDTH{1'b0}};
			pin_sync_out <= {WIDTH{1'b0}};
		end else begin
			stage1_r     <= pin_in;
			pin_sync_out <= stage1_r;
		end
	end

endmodule

//--- rtl/updown_timer_counter.v
// Operation
// RQ1 - 16-bit count in two software bytes
// RQ2 - counter select picks clock or pin falls
// RQ3 - mode 00 div12, 01 div1, 10 ext/8
// RQ4 - mode 11 selects system clock div2
// RQ5 - decrement enabled: direction pin sets direction
// RQ6 - decrement disabled: always count up
// RQ7 - decrement enabled: direction pin triggers disabled
// RQ8 - output enable drives 50% toggle pin
// RQ9 - toggle state bit reads toggle level
// RQ10 - software sets up square wave registers
// RQ11 - toggle inverts each overflow, count reloads; code reloads only on up wrap, toggles only with output enable
// RQ12 - control picks capture/reload, config toggle; the capture/reload bit is only stored and read back, nothing captures
`timescale 1ns/1ps
`include "updown_timer_map.vh"

module updown_timer_counter (
	input  wire       clock,
	input  wire       srst,
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output reg  [7:0] sfr_rdata,
	input  wire       count_pin,
	input  wire       direction_pin,
	input  wire       ext_clock,
	output reg        toggle_pin,
	output reg        toggle_pin_oe,
	output reg        direction_trigger
);

	// register storage
	reg [7:0]  control_r;      // timer control register
	reg [7:0]  config_r;       // timer configuration register
	reg [15:0] reload_r;       // reload value high:low
	reg [15:0] count_r;        // count value high:low
	reg [15:0] count_nxt;
	reg        toggle_r;       // toggle output level
	reg        toggle_nxt;

	// prescalers and edge history
	reg [3:0]  div12_r;        // system clock / 12
	reg        div2_r;         // system clock / 2
	reg [2:0]  ext_div_r;      // external clock / 8
	reg        ext_prev_r;     // last synced external clock
	reg        cnt_prev_r;     // last synced count pin
	reg        dir_prev_r;     // last synced direction pin

	wire [2:0] pins_sync;      // synced ext clock, direction, count
	wire       cnt_s;
	wire       dir_s;
	wire       ext_s;
	reg        tick;           // one count step this cycle
	reg        up;             // count direction this step
	reg        overflow;       // wrap event this step

	// field views
	wire       counter_select       = control_r[`CTL_COUNTER_SELECT];
	wire       timer_run            = control_r[`CTL_RUN];
	wire       decrement_enable     = config_r[`CFG_DECREMENT_ENABLE];
	wire       toggle_output_enable = config_r[`CFG_TOGGLE_OE];
	wire [1:0] clock_mode = {config_r[`CFG_CLOCK_MODE_HI],
	                         config_r[`CFG_CLOCK_MODE_LO]};

	// strobe decode, shared by write paths
	function wr_hit;
		input [7:0] addr;
		input [7:0] target;
		input       wr;
		begin
			wr_hit = wr && (addr == target);
		end
	endfunction

	// all pins pass two flip-flops first
	pin_sync #(
		.WIDTH (3)
	) u_sync (
		.clock        (clock),
		.srst         (srst),
		.pin_in       ({ext_clock, direction_pin, count_pin}),
		.pin_sync_out (pins_sync)
	);

	assign cnt_s = pins_sync[0];
	assign dir_s = pins_sync[1];
	assign ext_s = pins_sync[2];

	// prescalers and edge history run freely
	always @(posedge clock) begin
		if (srst) begin
			div12_r    <= 4'h0;
			div2_r     <= 1'b0;
			ext_div_r  <= 3'h0;
			ext_prev_r <= 1'b0;
			cnt_prev_r <= 1'b0;
			dir_prev_r <= 1'b0;
		end else begin
			if (div12_r == `DIV12_LAST) begin
				div12_r <= 4'h0;
			end else begin
				div12_r <= div12_r + 4'h1;
			end
			div2_r     <= ~div2_r;
			if (ext_s && !ext_prev_r) begin
				ext_div_r <= ext_div_r + 3'h1;
			end
			ext_prev_r <= ext_s;
			cnt_prev_r <= cnt_s;
			dir_prev_r <= dir_s;
		end
	end

	// pick the count step and direction
	always @* begin
		tick = 1'b0;
		if (counter_select) begin
			// falling edge on count pin
			tick = cnt_prev_r && !cnt_s;                      // [RQ2]
		end else begin
			case (clock_mode)                                 // [RQ3]
				`MODE_DIV12:    tick = (div12_r == `DIV12_LAST);
				`MODE_DIV1:     tick = 1'b1;
				`MODE_EXT_DIV8: tick = ext_s && !ext_prev_r &&
				                      (ext_div_r == `EXT_DIV8_LAST);
				`MODE_DIV2:     tick = div2_r;                // [RQ4]
				default:        tick = 1'b0;
			endcase
		end
		tick = tick && timer_run;
		// direction pin only counts when decrement enabled
		up = decrement_enable ? dir_s : 1'b1;                 // [RQ5] [RQ6]
	end

	// next count with reload on overflow, restart from full on underflow
	always @* begin
		count_nxt  = count_r;
		toggle_nxt = toggle_r;
		overflow   = 1'b0;
		if (tick) begin
			if (up) begin
				if (count_r == `COUNT_FULL) begin
					// wrap up: reload from reload value
					count_nxt = reload_r;                 // [RQ11]
					overflow  = 1'b1;
				end else begin
					count_nxt = count_r + 16'h0001;
				end
			end else begin
				if (count_r == reload_r) begin
					// wrap down: restart from full
					count_nxt = `COUNT_FULL;
					overflow  = 1'b1;
				end else begin
					count_nxt = count_r - 16'h0001;
				end
			end
		end
		// toggle level flips on each overflow while output enable set
		if (overflow && toggle_output_enable) begin
			toggle_nxt = ~toggle_r;                           // [RQ11]
		end
	end

	// register writes and count update
	always @(posedge clock) begin
		if (srst) begin
			control_r <= `RESET_CONTROL;
			config_r  <= `RESET_CONFIG;
			reload_r  <= {`RESET_BYTE, `RESET_BYTE};
			count_r   <= {`RESET_BYTE, `RESET_BYTE};
			toggle_r  <= 1'b0;
		end else begin
			count_r  <= count_nxt;
			toggle_r <= toggle_nxt;
			// capture/reload select kept in control register
			if (wr_hit(sfr_addr, `ADDR_TIMER_CONTROL, sfr_wr)) begin
				control_r <= sfr_wdata & `CTL_MASK;           // [RQ12]
			end
			// toggle mode lives in configuration register
			if (wr_hit(sfr_addr, `ADDR_TIMER_CONFIG, sfr_wr)) begin
				config_r <= sfr_wdata & `CFG_MASK;            // [RQ12]
				// writing toggle state forces the output level
				toggle_r <= sfr_wdata[`CFG_TOGGLE_STATE];
			end
			if (wr_hit(sfr_addr, `ADDR_RELOAD_LOW, sfr_wr)) begin
				reload_r[7:0] <= sfr_wdata;                   // [RQ10]
			end
			if (wr_hit(sfr_addr, `ADDR_RELOAD_HIGH, sfr_wr)) begin
				reload_r[15:8] <= sfr_wdata;                  // [RQ10]
			end
			// software byte writes win over counting
			if (wr_hit(sfr_addr, `ADDR_COUNT_LOW, sfr_wr)) begin
				count_r[7:0] <= sfr_wdata;                    // [RQ1]
			end
			if (wr_hit(sfr_addr, `ADDR_COUNT_HIGH, sfr_wr)) begin
				count_r[15:8] <= sfr_wdata;                   // [RQ1]
			end
		end
	end

	// registered read data, one cycle after the read strobe
	always @(posedge clock) begin
		if (srst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				`ADDR_TIMER_CONTROL: sfr_rdata <= control_r;
				// reserved bits read zero, toggle state live
				`ADDR_TIMER_CONFIG:  sfr_rdata <= {3'h0,
				        config_r[4:3], toggle_r,              // [RQ9]
				        config_r[1:0]};
				`ADDR_RELOAD_LOW:    sfr_rdata <= reload_r[7:0];
				`ADDR_RELOAD_HIGH:   sfr_rdata <= reload_r[15:8];
				`ADDR_COUNT_LOW:     sfr_rdata <= count_r[7:0];  // [RQ1]
				`ADDR_COUNT_HIGH:    sfr_rdata <= count_r[15:8]; // [RQ1]
				default:             sfr_rdata <= 8'h00;
			endcase
		end
	end

	// pin outputs from flip-flops
	always @(posedge clock) begin
		if (srst) begin
			toggle_pin        <= 1'b0;
			toggle_pin_oe     <= 1'b0;
			direction_trigger <= 1'b0;
		end else begin
			// toggle wave only while output enable set
			toggle_pin    <= toggle_nxt & toggle_output_enable; // [RQ8]
			toggle_pin_oe <= toggle_output_enable;               // [RQ8]
			// falling edge trigger suppressed in decrement mode
			direction_trigger <= dir_prev_r && !dir_s &&
			                     !decrement_enable;              // [RQ7]
		end
	end

endmodule

//--- testbench/pin_partner.sv
`timescale 1ns/1ps
// stands in for the pins around one timer
module pin_partner (
	output reg count_pin,
	output reg direction_pin,
	output reg ext_clock
);
	// idle levels: count line high so only commanded pulses fall
	initial begin
		count_pin = 1'b1;
		direction_pin = 1'b1;
		ext_clock = 1'b0;
	end
	// low-going pulses, each level held three system clocks
	task automatic pulse(input int n);
		repeat (n) begin
			#60 count_pin = 1'b0;
			#60 count_pin = 1'b1;
		end
	endtask
	// external clock cycles, stopped between bursts; edges land on
	// falling system clock edges, last rise settles before the end
	task automatic ext(input int n);
		repeat (n) begin
			#40 ext_clock = 1'b1;
			#60 ext_clock = 1'b0;
		end
	endtask
	// direction level, high means up
	task automatic dir(input logic v);
		direction_pin = v;
	endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
	logic       clock, srst, sfr_wr, sfr_rd;
	logic [7:0] sfr_addr, sfr_wdata;
	wire  [7:0] sfr_rdata;
	wire        count_pin, direction_pin, ext_clock;
	wire        toggle_pin, toggle_pin_oe, direction_trigger;
	int         err_total, check_count, n;
	logic [7:0] rv;   // last byte read
	logic       seen; // trigger pulse observed
	logic [1:0] md[3] = '{2'b01, 2'b11, 2'b00}; // clock mode codes
	int         dv[3] = '{1, 2, 12};            // their divide ratios
	updown_timer_counter dut (
		.clock             (clock),
		.srst              (srst),
		.sfr_addr          (sfr_addr),
		.sfr_wr            (sfr_wr),
		.sfr_rd            (sfr_rd),
		.sfr_wdata         (sfr_wdata),
		.sfr_rdata         (sfr_rdata),
		.count_pin         (count_pin),
		.direction_pin     (direction_pin),
		.ext_clock         (ext_clock),
		.toggle_pin        (toggle_pin),
		.toggle_pin_oe     (toggle_pin_oe),
		.direction_trigger (direction_trigger)
	);
	pin_partner pp (
		.count_pin     (count_pin),
		.direction_pin (direction_pin),
		.ext_clock     (ext_clock)
	);
	// free-running system clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic wr(input logic [7:0] a, d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		rv = sfr_rdata;
	endtask
	// clears the count, runs 48 clocks, checks low byte within one
	task automatic run_win(input int e);
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		wr(8'hc8, 8'h04);
		repeat (46) @(negedge clock);
		wr(8'hc8, 8'h00);
		rd(8'hcc);
		`CHK("count window", 1'b1, (rv >= e - 1 && rv <= e + 1))
	endtask
	// drops the direction pin and looks for a trigger pulse
	task automatic trig(input logic [7:0] c, input logic e);
		wr(8'hc9, c);
		pp.dir(1'b1);
		repeat (4) @(negedge clock);
		pp.dir(1'b0);
		seen = 1'b0;
		repeat (10) begin
			@(negedge clock);
			seen = seen | direction_trigger;
		end
		`CHK("dir trigger", e, seen)
	endtask
	// clocks spent at one toggle level, bounded
	task automatic meas(input logic lv);
		n = 0;
		while (toggle_pin === lv && n < 100) begin
			@(negedge clock);
			n++;
		end
		// a level that never ends counts as a mismatch
		if (n >= 100) begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// main sequence
	initial begin
		{srst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 19'h40000;
		{err_total, check_count} = 0;
		repeat (10) @(negedge clock);
		srst = 1'b0;
		rd(8'hc9);
		`CHK("cfg reset", 8'h00, rv)
		rd(8'hc0);
		`CHK("unmapped", 8'h00, rv)
		wr(8'hc9, 8'hff);
		rd(8'hc9);
		`CHK("cfg mask", 8'h1f, rv)
		wr(8'hcd, 8'ha5);
		rd(8'hcd);
		`CHK("count high", 8'ha5, rv)
		wr(8'hc8, 8'hff);
		rd(8'hc8);
		`CHK("ctl mask", 8'h07, rv)
		pp.dir(1'b0);
		for (int m = 0; m < 3; m++) begin
			wr(8'hc9, {3'h0, md[m], 3'h0});
			run_win(48 / dv[m]);
		end
		wr(8'hc9, 8'h09);
		run_win(8'hd0);
		pp.dir(1'b1);
		run_win(48);
		wr(8'hc9, 8'h00);
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		wr(8'hc8, 8'h06);
		pp.pulse(5);
		rd(8'hcc);
		`CHK("pin count", 8'h05, rv)
		wr(8'hc8, 8'h00);
		wr(8'hcc, 8'h00);
		wr(8'hc9, 8'h10);
		wr(8'hc8, 8'h04);
		pp.ext(16);
		rd(8'hcc);
		`CHK("ext count", 8'h02, rv)
		trig(8'h00, 1'b1);
		trig(8'h01, 1'b0);
		wr(8'hc8, 8'h00);
		wr(8'hc9, 8'h0a);
		wr(8'hca, 8'hf0);
		wr(8'hcb, 8'hff);
		wr(8'hcc, 8'hfe);
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h04);
		meas(1'b0);
		meas(1'b1);
		`CHK("high time", 16, n)
		meas(1'b0);
		`CHK("low time", 16, n)
		rd(8'hc9);
		`CHK("toggle state", 8'h0e, rv)
		wr(8'hc9, 8'h08);
		repeat (3) @(negedge clock);
		`CHK("pin off", 2'b00, {toggle_pin_oe, toggle_pin})
		end_of_test();
	end
endmodule
bind updown_timer_counter updown_timer_asserts chk (
	.clock             (clock),
	.srst              (srst),
	.sfr_addr          (sfr_addr),
	.sfr_wr            (sfr_wr),
	.sfr_rd            (sfr_rd),
	.sfr_wdata         (sfr_wdata),
	.sfr_rdata         (sfr_rdata),
	.toggle_pin        (toggle_pin),
	.toggle_pin_oe     (toggle_pin_oe),
	.direction_trigger (direction_trigger)
);

//--- testbench/updown_timer_asserts.sv
`timescale 1ns/1ps
// watches the register bus and pins of one timer
module updown_timer_asserts (
	input wire       clock,
	input wire       srst,
	input wire [7:0] sfr_addr,
	input wire       sfr_wr,
	input wire       sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire       toggle_pin,
	input wire       toggle_pin_oe,
	input wire       direction_trigger
);
	reg [7:0] cfg_r; // shadow of the configuration byte
	// shadow follows each configuration write
	always @(posedge clock) begin
		if (srst)
			cfg_r <= 8'h00;
		else if (sfr_wr && sfr_addr == 8'hc9)
			cfg_r <= sfr_wdata;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence cfg_wr_s;
		sfr_wr && sfr_addr == 8'hc9;
	endsequence
	sequence cfg_rd_s;
		sfr_rd && sfr_addr == 8'hc9;
	endsequence
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	unmapped_rd_a: assert property (sfr_rd && (sfr_addr < 8'hc8 ||
		sfr_addr > 8'hcd) |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	cfg_echo_a: assert property (cfg_wr_s ##2 cfg_rd_s |=>
		{sfr_rdata[7:5], sfr_rdata[4:3], sfr_rdata[1:0]} ==
		{3'h0, $past(sfr_wdata[4:3], 3), $past(sfr_wdata[1:0], 3)})
		else $error("config readback wrong");
	tog_read_a: assert property (cfg_rd_s and (cfg_r[1] &&
		$past(cfg_r[1])) |=> sfr_rdata[2] == $past(toggle_pin))
		else $error("toggle state bit wrong");
	oe_on_a: assert property (cfg_r[1] && $past(cfg_r[1])
		|-> toggle_pin_oe) else $error("toggle output not driven");
	oe_off_a: assert property (!cfg_r[1] && !$past(cfg_r[1])
		|-> !toggle_pin_oe && !toggle_pin)
		else $error("toggle output while disabled");
	trig_off_a: assert property (cfg_r[0] && $past(cfg_r[0])
		|-> !direction_trigger) else $error("trigger while decrementing");
	rst_clear_a: assert property ($fell(srst) |-> sfr_rdata == 8'h00
		&& !toggle_pin_oe) else $error("outputs not cleared by reset");
endmodule
